//--- rtl/adc_ctrl_defines.svh
// Register offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Special function register addresses
// ----------------------------------------------------------------------------
`define ADDR_PIN_OPTION      8'hD9
`define ADDR_CHANNEL_CTRL    8'hDA
`define ADDR_RESULT_UPPER    8'hDB
`define ADDR_RESULT_LOWER    8'hDC

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT      7
`define CTRL_DONE_BIT        4
`define CHANNELS             4
`define RESULT_BITS          10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PIN_OPTION       4'h0
`define RST_CHANNEL_SELECT   4'h0
`define RST_RESULT           10'h000

// ----------------------------------------------------------------------------
// Timing: one successive-approximation step every three cycles, plus two sample cycles
// ----------------------------------------------------------------------------
`define SAMPLE_CYCLES        4'h1

`endif

//--- rtl/adc_ctrl_pkg.sv
// Types shared by the converter control block.
package adc_ctrl_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b10,
      ST_STORE  = 2'b11
   } conv_state_t;

endpackage : adc_ctrl_pkg

//--- rtl/sar_step.sv
// Successive-approximation bit walk: trial code and comparator-driven decisions.
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"

module sar_step #(
   parameter int WIDTH = `RESULT_BITS
)(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Control
   input  wire logic             start_i,
   input  wire logic             step_i,
   input  wire logic             comp_i,
   // Result
   output logic [WIDTH-1:0]      trial_o,
   output logic                  last_o
);

   logic [WIDTH-1:0] code_r;
   logic [WIDTH-1:0] mask_r;

   assign trial_o = code_r | mask_r;
   assign last_o  = mask_r[0];

   // A comparator high means the trial voltage is below the input, so the bit stays.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         code_r <= '0;
         mask_r <= '0;
      end
      else if (start_i)
      begin
         code_r <= '0;
         mask_r <= {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (step_i)
      begin
         code_r <= comp_i ? (code_r | mask_r) : code_r;
         mask_r <= mask_r >> 1;
      end
   end

endmodule : sar_step

//--- rtl/sync2.sv
// Two flip-flop synchroniser for levels from outside the clock domain.
`timescale 1ns/100ps

module sync2 #(
   parameter int WIDTH = 1
)(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Data
   input  wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0]      q_o
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_r <= '0;
         q_o    <= '0;
      end
      else
      begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end

endmodule : sync2

//--- rtl/sar_adc_register_interface.sv
// Control, channel selection and result registers of the 10-bit successive-approximation converter.
//
// Behaviour
// - Pin-option register implements only bits 3..0; upper bits read zero.
// - Analog pin enable bit n turns port pin n+4 into analog channel n.
// - Enable bit zero (reset) leaves pin as ordinary port bit or pulse output.
// - Enable at bit 7 resets to zero; setting it starts conversion on selected channel.
// - Select bits 3..0 pick channels 3..0; zero deselects; all reset zero.
// - Each finished conversion stored as 10-bit code split over two result registers.
// - Upper result register holds result bits 9..2, resets to zero.
// - Lower result register holds bits 1..0, reset zero; upper six read zero.
// - Idle or stop switches converter off, aborts conversion, results kept.
// - The four registers sit at special function addresses D9, DA, DB, DC.
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"

module sar_adc_register_interface
   import adc_ctrl_pkg::*;
#(
   parameter int RES_W = `RESULT_BITS,
   parameter int CH_N  = `CHANNELS
)(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   // Special function register port
   input  wire logic [7:0]        sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic              sfr_rd_i,
   input  wire logic [7:0]        sfr_wdata_i,
   output logic      [7:0]        sfr_rdata_o,
   output logic                   sfr_hit_o,
   // Power-saving modes
   input  wire logic              idle_mode_i,
   input  wire logic              stop_mode_i,
   // Pin multiplexing for port pins four to seven
   output logic      [CH_N-1:0]   analog_pin_enable_o,
   output logic      [CH_N-1:0]   digital_pin_enable_o,
   // Analog core
   output logic      [CH_N-1:0]   channel_select_o,
   output logic                   sample_o,
   output logic                   converter_on_o,
   output logic      [RES_W-1:0]  dac_code_o,
   input  wire logic              comparator_i,
   // Status
   output logic                   conversion_done_o
);

   // ----------------------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------------------
   logic [CH_N-1:0]  pin_option_r;
   logic [CH_N-1:0]  channel_select_r;
   logic             converter_enable_r;
   logic             done_r;
   logic [7:0]       result_upper_r;
   logic [1:0]       result_lower_r;
   conv_state_t      state_r;
   conv_state_t      state_nxt;
   logic [3:0]       sample_cnt_r;
   logic             comp_sync;
   logic             sar_last;
   logic [RES_W-1:0] sar_trial;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   wire sel_pin   = hit(sfr_addr_i, `ADDR_PIN_OPTION);
   wire sel_ctrl  = hit(sfr_addr_i, `ADDR_CHANNEL_CTRL);
   wire sel_upper = hit(sfr_addr_i, `ADDR_RESULT_UPPER);
   wire sel_lower = hit(sfr_addr_i, `ADDR_RESULT_LOWER);
   wire wr_pin    = sfr_wr_i && sel_pin;
   wire wr_ctrl   = sfr_wr_i && sel_ctrl;
   wire wr_upper  = sfr_wr_i && sel_upper;
   wire wr_lower  = sfr_wr_i && sel_lower;
   wire power_save = idle_mode_i || stop_mode_i;
   // An enable write during power saving is dropped, so no conversion starts while the core is off.
   wire start_req = wr_ctrl && sfr_wdata_i[`CTRL_ENABLE_BIT] && !power_save;
   // A conversion that reaches its store step just as power saving begins is abandoned like any other.
   wire finish    = (state_r == ST_STORE) && !power_save;

   assign sfr_hit_o = sel_pin || sel_ctrl || sel_upper || sel_lower;

   // ----------------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pin_option_r       <= `RST_PIN_OPTION;
         channel_select_r   <= `RST_CHANNEL_SELECT;
         converter_enable_r <= 1'b0;
      end
      else
      begin
         if (wr_pin)
            pin_option_r <= sfr_wdata_i[CH_N-1:0];
         if (wr_ctrl)
            channel_select_r <= sfr_wdata_i[CH_N-1:0];
         // Power saving forces the enable low so the converter stays off until software restarts it.
         if (power_save)
            converter_enable_r <= 1'b0;
         else if (wr_ctrl)
            converter_enable_r <= sfr_wdata_i[`CTRL_ENABLE_BIT];
      end
   end

   // The done flag is hardware set and cleared by a write of zero; a completion in the same cycle wins.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         done_r <= 1'b0;
      else if (finish)
         done_r <= 1'b1;
      else if (wr_ctrl && !sfr_wdata_i[`CTRL_DONE_BIT])
         done_r <= 1'b0;
      else if (start_req)
         done_r <= 1'b0;
   end

   // Result registers are CPU writable; a finishing conversion takes priority over the write.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         result_upper_r <= 8'(`RST_RESULT >> 2);
         result_lower_r <= 2'h0;
      end
      else if (finish)
      begin
         result_upper_r <= sar_trial[RES_W-1:2];
         result_lower_r <= sar_trial[1:0];
      end
      else
      begin
         if (wr_upper)
            result_upper_r <= sfr_wdata_i;
         if (wr_lower)
            result_lower_r <= sfr_wdata_i[1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------------------
   sync2 #(.WIDTH(1)) u_comp_sync
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .d_i       (comparator_i),
      .q_o       (comp_sync)
   );

   // The comparator reaches logic two cycles late, so each decision waits on a settle window.
   logic [1:0] settle_r;
   wire        step_now = (state_r == ST_CONV) && (settle_r == 2'h2);

   // Power saving overrides every state, which abandons a conversion and leaves both results untouched.
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:   if (start_req) state_nxt = ST_SAMPLE;
         ST_SAMPLE: if (sample_cnt_r == `SAMPLE_CYCLES) state_nxt = ST_CONV;
         ST_CONV:   if (step_now && sar_last) state_nxt = ST_STORE;
         ST_STORE:  state_nxt = ST_IDLE;
         default:   state_nxt = ST_IDLE;
      endcase
      if (power_save)
         state_nxt = ST_IDLE;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r      <= ST_IDLE;
         sample_cnt_r <= 4'h0;
         settle_r     <= 2'h0;
      end
      else
      begin
         state_r      <= state_nxt;
         sample_cnt_r <= (state_r == ST_SAMPLE) ? sample_cnt_r + 4'h1 : 4'h0;
         settle_r     <= (state_r != ST_CONV || step_now) ? 2'h0 : settle_r + 2'h1;
      end
   end

   // The bit walk reloads on every sample cycle, so each conversion begins at mid-scale.
   sar_step #(.WIDTH(RES_W)) u_sar
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .start_i   (state_r == ST_SAMPLE),
      .step_i    (step_now),
      .comp_i    (comp_sync),
      .trial_o   (sar_trial),
      .last_o    (sar_last)
   );

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < CH_N; g++)
      begin : g_pin
         assign analog_pin_enable_o[g]  = pin_option_r[g];
         assign digital_pin_enable_o[g] = !pin_option_r[g];
      end
   endgenerate

   // Several select bits at once pass straight through; the result is then undefined.
   assign channel_select_o  = channel_select_r;
   assign sample_o          = (state_r == ST_SAMPLE);
   assign converter_on_o    = (state_r != ST_IDLE);
   assign dac_code_o        = sar_trial;
   assign conversion_done_o = done_r;

   // Read data is zero outside a read or a mapped address, so several blocks can share one read bus by OR.
   always_comb
   begin
      sfr_rdata_o = 8'h00;
      if (sfr_rd_i)
      begin
         if (sel_pin)
            sfr_rdata_o = {4'h0, pin_option_r};
         else if (sel_ctrl)
            sfr_rdata_o = {converter_enable_r, 2'b00, done_r, channel_select_r};
         else if (sel_upper)
            sfr_rdata_o = result_upper_r;
         else if (sel_lower)
            sfr_rdata_o = {6'h00, result_lower_r};
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_done_on_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      finish |=> done_r && result_upper_r == $past(sar_trial[RES_W-1:2]))
      else $error("done flag or upper result not updated after conversion");
   a_lower_stored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      finish |=> result_lower_r == $past(sar_trial[1:0]))
      else $error("lower result not updated after conversion");
   a_abort_power: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      power_save |=> state_r == ST_IDLE && !converter_enable_r)
      else $error("converter still running in power saving mode");
   a_results_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      power_save && !wr_upper && !wr_lower |=> $stable(result_upper_r) && $stable(result_lower_r))
      else $error("result changed during power saving mode");
   a_start_conv: assert property (@(posedge clk_i) disable iff (!reset_n_i || power_save)
      start_req && state_r == ST_IDLE |=> sample_o ##1 sample_o ##1 state_r == ST_CONV)
      else $error("conversion did not start after enable write");
   a_pin_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_pin |=> analog_pin_enable_o == $past(sfr_wdata_i[3:0]) && digital_pin_enable_o == ~analog_pin_enable_o)
      else $error("pin option not applied to pins");
   a_pin_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sfr_rd_i && sel_pin |-> sfr_rdata_o[7:4] == 4'h0)
      else $error("unimplemented pin option bits read nonzero");
   a_ctrl_readback: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_ctrl ##1 !wr_ctrl ##1 (sfr_rd_i && sel_ctrl) |-> sfr_rdata_o[3:0] == $past(sfr_wdata_i[3:0], 2))
      else $error("channel select read back wrong");
   a_conv_bounded: assert property (@(posedge clk_i) disable iff (!reset_n_i || power_save)
      $rose(state_r == ST_CONV) |-> ##[29:31] finish)
      else $error("conversion length out of bound");

   // Register write and read-path checks.
   a_unmapped_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sfr_rd_i && !sfr_hit_o |-> sfr_rdata_o == 8'h00)
      else $error("unmapped address read nonzero");
   a_lower_unused: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      sfr_rd_i && sel_lower |-> sfr_rdata_o[7:2] == 6'h00)
      else $error("unimplemented lower result bits read nonzero");
   a_enable_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_ctrl && !power_save |=> converter_enable_r == $past(sfr_wdata_i[`CTRL_ENABLE_BIT]))
      else $error("enable bit not written");
   a_select_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_ctrl |=> channel_select_o == $past(sfr_wdata_i[CH_N-1:0]))
      else $error("channel select not written");
   a_upper_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wr_upper && !finish |=> result_upper_r == $past(sfr_wdata_i))
      else $error("upper result not written");

   // Conversion and flag checks.
   a_done_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      done_r && !wr_ctrl |=> done_r)
      else $error("done flag lost without a clear");
   a_start_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      start_req && !finish |=> !done_r)
      else $error("done flag not cleared by a new start");
   a_sample_len: assert property (@(posedge clk_i) disable iff (!reset_n_i || power_save)
      $rose(sample_o) |=> sample_o ##1 !sample_o)
      else $error("sample phase length wrong");

   c_full_conv:  cover property (@(posedge clk_i) disable iff (!reset_n_i) finish);
   c_abort:      cover property (@(posedge clk_i) disable iff (!reset_n_i) state_r == ST_CONV && power_save);
   c_set_clear:  cover property (@(posedge clk_i) disable iff (!reset_n_i) finish && wr_ctrl);
   c_analog_pin: cover property (@(posedge clk_i) disable iff (!reset_n_i) analog_pin_enable_o == 4'hF);
   c_ctrl_read:  cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_ctrl ##1 !wr_ctrl ##1 (sfr_rd_i && sel_ctrl));

endmodule : sar_adc_register_interface

//--- bench/analog_source.sv
// Behavioural model of the analog sources and comparator behind the shared port pins.
`timescale 1ns/100ps

module analog_source
(
   // Clock
   input  wire logic        clk_i,
   // From the converter
   input  wire logic [3:0]  analog_pin_enable_i,
   input  wire logic [3:0]  channel_select_i,
   input  wire logic [9:0]  dac_code_i,
   // Ideal input levels, channel n in bits n*10+9 .. n*10
   input  wire logic [39:0] level_i,
   // Comparator
   output logic             comparator_o
);
   logic       toggle_r = 1'b0;
   logic [9:0] level;
   logic       valid;

   // A pin left digital carries no level, so the comparator only chatters there.
   assign valid = $onehot(channel_select_i) && |(channel_select_i & analog_pin_enable_i);

   always_comb
   begin
      level = 10'h000;
      for (int n = 0; n < 4; n++)
         if (channel_select_i[n])
            level = level_i[n*10 +: 10];
   end

   always_ff @(posedge clk_i)
      toggle_r <= ~toggle_r;

   assign comparator_o = valid ? (level >= dac_code_i) : toggle_r;
endmodule : analog_source

//--- bench/tb.sv
// Self-checking testbench of the converter register interface.
`timescale 1ns/100ps
`include "adc_ctrl_defines.svh"

module tb;
   logic        clk_i       = 1'b0;
   logic        reset_n_i   = 1'b0;
   logic [7:0]  sfr_addr_i  = 8'h00;
   logic        sfr_wr_i    = 1'b0;
   logic        sfr_rd_i    = 1'b0;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic        idle_mode_i = 1'b0;
   logic        stop_mode_i = 1'b0;
   logic [7:0]  sfr_rdata_o;
   logic        sfr_hit_o;
   logic [3:0]  analog_pin_enable_o;
   logic [3:0]  digital_pin_enable_o;
   logic [3:0]  channel_select_o;
   logic        sample_o;
   logic        converter_on_o;
   logic [9:0]  dac_code_o;
   logic        comparator_i;
   logic        conversion_done_o;
   logic [39:0] level = {10'h15A, 10'h2A5, 10'h000, 10'h3FF};
   int          error_cnt = 0;
   int          comparisons = 0;

   sar_adc_register_interface dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .sfr_hit_o(sfr_hit_o), .idle_mode_i(idle_mode_i), .stop_mode_i(stop_mode_i),
      .analog_pin_enable_o(analog_pin_enable_o), .digital_pin_enable_o(digital_pin_enable_o),
      .channel_select_o(channel_select_o), .sample_o(sample_o), .converter_on_o(converter_on_o),
      .dac_code_o(dac_code_o), .comparator_i(comparator_i), .conversion_done_o(conversion_done_o));

   analog_source src_u (.clk_i(clk_i), .analog_pin_enable_i(analog_pin_enable_o),
      .channel_select_i(channel_select_o), .dac_code_i(dac_code_o), .level_i(level),
      .comparator_o(comparator_i));

   initial
   begin
      forever #50 clk_i = ~clk_i;
   end

   task check(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i  = a;
      sfr_wdata_i = d;
      sfr_wr_i    = 1'b1;
      @(negedge clk_i);
      sfr_wr_i    = 1'b0;
   endtask : wr

   // Read data is combinational, so it is sampled 40 ns after the falling edge, just before the next rising edge.
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_rd_i   = 1'b1;
      #40;
      check({2'b00, sfr_rdata_o}, {2'b00, exp});
      @(negedge clk_i);
      sfr_rd_i   = 1'b0;
   endtask : rd

   task wait_done;
      int i;
      i = 0;
      while (conversion_done_o !== 1'b1 && i < 200)
      begin
         @(negedge clk_i);
         i++;
      end
      check({9'h000, conversion_done_o}, 10'h001);
   endtask : wait_done

   task results;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // A whole run takes under 300 cycles; the limit leaves ample margin.
   initial
   begin
      #400000;
      error_cnt++;
      results();
   end

   initial
   begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      reset_n_i = 1'b1;
      rd(`ADDR_PIN_OPTION, 8'h00);
      rd(`ADDR_CHANNEL_CTRL, 8'h00);
      rd(`ADDR_RESULT_UPPER, 8'h00);
      rd(`ADDR_RESULT_LOWER, 8'h00);
      check({6'h00, digital_pin_enable_o}, 10'h00F);
      wr(8'hD8, 8'hFF);
      rd(8'hDD, 8'h00);
      check({9'h000, sfr_hit_o}, 10'h000);
      rd(`ADDR_PIN_OPTION, 8'h00);
      for (int n = 0; n < 4; n++)
      begin
         wr(`ADDR_PIN_OPTION, 8'h01 << n);
         check({6'h00, analog_pin_enable_o}, 10'h001 << n);
         check({6'h00, digital_pin_enable_o}, {6'h00, ~(4'h1 << n)});
      end
      wr(`ADDR_PIN_OPTION, 8'hFF);
      rd(`ADDR_PIN_OPTION, 8'h0F);
      check({9'h000, sfr_hit_o}, 10'h001);
      wr(`ADDR_RESULT_LOWER, 8'hFF);
      rd(`ADDR_RESULT_LOWER, 8'h03);
      wr(`ADDR_RESULT_UPPER, 8'hA5);
      rd(`ADDR_RESULT_UPPER, 8'hA5);
      for (int n = 0; n < 4; n++)
      begin
         wr(`ADDR_CHANNEL_CTRL, 8'h01 << n);
         wr(`ADDR_CHANNEL_CTRL, 8'h80 | (8'h01 << n));
         @(negedge clk_i);
         check({9'h000, converter_on_o}, 10'h001);
         check({6'h00, channel_select_o}, 10'h001 << n);
         check({9'h000, sample_o}, 10'h001);
         check(dac_code_o, 10'h200);
         wait_done();
         rd(`ADDR_RESULT_UPPER, level[n*10+2 +: 8]);
         rd(`ADDR_RESULT_LOWER, {6'h00, level[n*10 +: 2]});
         rd(`ADDR_CHANNEL_CTRL, 8'h90 | (8'h01 << n));
      end
      wr(`ADDR_CHANNEL_CTRL, 8'h01);
      wr(`ADDR_CHANNEL_CTRL, 8'h81);
      repeat (6) @(negedge clk_i);
      idle_mode_i = 1'b1;
      repeat (2) @(negedge clk_i);
      check({9'h000, converter_on_o}, 10'h000);
      repeat (40) @(negedge clk_i);
      check({9'h000, conversion_done_o}, 10'h000);
      rd(`ADDR_RESULT_UPPER, level[32 +: 8]);
      rd(`ADDR_RESULT_LOWER, {6'h00, level[30 +: 2]});
      idle_mode_i = 1'b0;
      wr(`ADDR_CHANNEL_CTRL, 8'h01);
      stop_mode_i = 1'b1;
      wr(`ADDR_CHANNEL_CTRL, 8'h81);
      rd(`ADDR_CHANNEL_CTRL, 8'h01);
      check({9'h000, converter_on_o}, 10'h000);
      stop_mode_i = 1'b0;
      results();
   end
endmodule : tb
